// ===== core/di_func_consts.vh
// constants for the digital input function decoder
`ifndef DI_FUNC_CONSTS_VH
`define DI_FUNC_CONSTS_VH

// ==========================================================
// function codes
`define FN_STOP_EXT1 6'h1C
`define FN_STOP_EXT2 6'h1D
`define FN_ESTOP 6'h1E
`define FN_PID_PAUSE 6'h1F
`define FN_PID_INT_PAUSE 6'h20
`define FN_PID_REVERSE 6'h21
`define FN_PID_GAIN_SW 6'h22
`define FN_SEQ_PAUSE 6'h23
`define FN_SEQ_RESET 6'h24
`define FN_SWING_PAUSE 6'h25
`define FN_SWING_RESET 6'h26
`define FN_MODE_SW 6'h27
`define FN_TORQUE_PROHIBIT 6'h28
`define FN_RAMP_PROHIBIT 6'h29
`define FN_REV_PROHIBIT 6'h2A
`define FN_FREQ_PROHIBIT 6'h2B
`define FN_CNT_IN 6'h2C
`define FN_CNT_RST 6'h2D
`define FN_LEN_IN 6'h2E
`define FN_LEN_RST 6'h2F
`define FN_MOTOR_SEL 6'h30
`define FN_USER_FAULT1 6'h32
`define FN_USER_FAULT2 6'h33
`define FN_RUNTIME_CLR 6'h34
`define FN_WIRE_SW 6'h35

// ==========================================================
// command sources, gain switch condition, decel selector
`define SRC_KEYPAD 2'h0
`define GAIN_SW_TERMINAL 2'h1
`define DECEL_SEL_FOURTH 2'h3

// ==========================================================
// bus offsets and reset values
`define OFS_TERM_FUNC 12'h000
`define OFS_POLARITY 12'h020
`define OFS_CONFIG 12'h024
`define OFS_STATUS 12'h028
`define OFS_COUNTER 12'h02C
`define OFS_LENGTH 12'h030
`define OFS_CMD 12'h034
`define OFS_FUNC_STAT 12'h038
`define RST_FUNC 6'h00
`define RST_POLARITY 6'h00
`define RST_CONFIG 32'h00000000
`define CFG_SRC_LSB 0
`define CFG_GAIN_LSB 2
`define CFG_TORQUE_BIT 4
`define CFG_THREE_WIRE_BIT 5
`define NUM_TERM 6
`define NUM_FUNC 64

`endif

// ===== core/di_func_decoder.v
// multi-function digital input decoder, functions 28 to 53
// ==========================================================
// Functional notes
// - stop terminal 1 stops only in keypad control
// - stop terminal 2 decelerates with fourth ramp
// - emergency stop uses configured stop time
// - PID pause holds output frequency
// - integral pause freezes only integral term
// - reverse PID flips configured direction
// - terminal selects second PID gain set
// - sequence reset restarts suspended sequence
// - swing pause outputs center frequency
// - swing reset returns to center, stays enabled
// - mode terminal swaps speed and torque
// - torque prohibit forces speed control
// - ramp prohibit holds frequency, stop obeyed
// - reverse prohibit blocks reverse runs
// - frequency prohibit defers setpoint changes
// - count pulses, clear on counter reset
// - accumulate length, clear on length reset
// - two terminals select four motor groups
// - user fault terminals raise user faults
// - clear running time counter
// - toggle wire mode, ignored while running
// - polarity 0 active high, 1 active low
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "di_func_consts.vh"

// ==========================================================
// register map, one aligned word each, only byte lane 0 written
// 0x000..0x014 function code of terminals 0..5, 0 means unused
// 0x018, 0x01C spare terminal slots: slave error, no effect
// 0x020 polarity, one bit per terminal, 1 selects active low
// 0x024 config
//   [1:0] command source, 0 is keypad control
//   [3:2] PID gain switch condition, 1 is terminal control
//   [4] torque control is the default mode
//   [5] wire mode value loaded by the command register
// 0x028 status, read only
//   [0] second gain set, [1] torque mode, [3:2] motor group
//   [4] sequence suspended, [5] drive running
//   [11:6] qualified terminals, [12] three-wire mode
// 0x02C pulse counter, read only
// 0x030 length count, read only
// 0x034 command, write only, reads zero
//   bit0 clears the counter, bit1 clears the length
//   bit2 loads the wire mode from config bit 5
// 0x038 active flags of function codes 32 to 63
// any other address answers slave error and zero data, except unaligned reads below 0x018, which return that terminal's code
//
// timing
// terminals are registered once on entry, then the command
// outputs are registered again: a terminal change shows on
// the outputs two edges after it is applied to term_i, three_wire_o three edges after
// a write answers one cycle after address and data are both
// held; a read answers one cycle after its address is taken
//
// limitations
// level functions are decoded from whatever terminal holds
// the code; two terminals on one code simply OR together
// motor selection uses the lowest and the highest terminals holding
// the motor code; a single such terminal drives bit 0 only
// counter and length count one per qualified rising edge,
// so a terminal held active counts once; they wrap at 2^32
// the emergency stop time is applied by the control core,
// this block only raises the request level
//
// hazards
// a function code change takes effect on the next edge, so an
// active terminal swaps its old function for its new one on that edge
// a polarity write flips qualified levels at once, which may
// look like a rising edge to the counters
// the wire toggle is edge driven; a request raised while the
// drive runs is dropped, not deferred

module di_func_decoder (
    input wire core_clk_i,
    input wire rst_i,
    // terminal levels and drive state
    input wire [5:0] term_i,
    input wire running_i,
    input wire seq_suspended_i,
    // AXI4-Lite slave
    input wire [11:0] s_awaddr_i,
    input wire s_awvalid_i,
    output wire s_awready_o,
    input wire [31:0] s_wdata_i,
    input wire [3:0] s_wstrb_i,
    input wire s_wvalid_i,
    output wire s_wready_o,
    output reg [1:0] s_bresp_o,
    output reg s_bvalid_o,
    input wire s_bready_i,
    input wire [11:0] s_araddr_i,
    input wire s_arvalid_i,
    output wire s_arready_o,
    output reg [31:0] s_rdata_o,
    output reg [1:0] s_rresp_o,
    output reg s_rvalid_o,
    input wire s_rready_i,
    // commands to the control core
    output reg stop_key_o,
    output reg decel_stop_o,
    output reg [1:0] decel_sel_o,
    output reg estop_o,
    output reg pid_hold_o,
    output reg pid_int_freeze_o,
    output reg pid_dir_invert_o,
    output reg pid_gain_second_o,
    output reg seq_pause_o,
    output reg seq_restart_o,
    output reg swing_pause_o,
    output reg swing_center_o,
    output reg torque_mode_o,
    output reg freq_hold_o,
    output reg rev_block_o,
    output reg setpoint_hold_o,
    output reg [1:0] motor_group_o,
    output reg user_fault1_o,
    output reg user_fault2_o,
    output reg runtime_clr_o,
    output reg three_wire_o
);

// ==========================================================
// register state
reg [5:0] func_ff [0:5];
reg [5:0] polarity_ff;
reg [5:0] config_ff;
reg [31:0] counter_ff;
reg [31:0] length_ff;
reg three_wire_ff;
reg [5:0] term_ff;
reg aw_got_ff, w_got_ff;
reg [11:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
// one loop index per process so no variable has two drivers
integer i;
integer j;
integer k;

// qualified terminal levels
wire [5:0] act = term_ff ^ polarity_ff;

// per-function active and rising flags
reg [63:0] fn_act;
reg [63:0] fn_rise;
reg [5:0] last_act_ff;
always @* begin
    fn_act = 64'h0;
    fn_rise = 64'h0;
    for (i = 0; i < `NUM_TERM; i = i + 1) begin
        if (act[i]) begin
            fn_act[func_ff[i]] = 1'b1;
        end
        if (act[i] && !last_act_ff[i]) begin
            fn_rise[func_ff[i]] = 1'b1;
        end
    end
end

// motor select: lowest and highest terminals mapped to motor selection
reg [1:0] motor_bits;
reg motor_first;
always @* begin
    motor_bits = 2'h0;
    motor_first = 1'b1;
    for (j = 0; j < `NUM_TERM; j = j + 1) begin
        if (func_ff[j] == `FN_MOTOR_SEL) begin
            if (motor_first) begin
                motor_bits[0] = act[j];
                motor_first = 1'b0;
            end else begin
                motor_bits[1] = act[j];
            end
        end
    end
end

// ==========================================================
// AXI4-Lite handshake
wire wr_go = aw_got_ff && w_got_ff && !s_bvalid_o;
assign s_awready_o = !aw_got_ff && !s_bvalid_o;
assign s_wready_o = !w_got_ff && !s_bvalid_o;
assign s_arready_o = !s_rvalid_o;
wire cmd_wr = wr_go && awaddr_ff == `OFS_CMD && wstrb_ff[0];
// spare terminal slots answer slave error, as the read side does
wire mapped_w = awaddr_ff[11:5] == 7'h00 && awaddr_ff[4:2] < 3'h6
    && awaddr_ff[1:0] == 2'h0
    || awaddr_ff == `OFS_POLARITY || awaddr_ff == `OFS_CONFIG
    || awaddr_ff == `OFS_CMD;

// write side capture and decode
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awaddr_ff <= 12'h000;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
        s_bvalid_o <= 1'b0;
        s_bresp_o <= 2'h0;
        polarity_ff <= `RST_POLARITY;
        config_ff <= 6'h00;
        for (k = 0; k < `NUM_TERM; k = k + 1) begin
            func_ff[k] <= `RST_FUNC;
        end
    end else begin
        if (s_awvalid_i && s_awready_o) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_awaddr_i;
        end
        if (s_wvalid_i && s_wready_o) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_wdata_i;
            wstrb_ff <= s_wstrb_i;
        end
        if (wr_go) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_bvalid_o <= 1'b1;
            s_bresp_o <= mapped_w ? 2'h0 : 2'h2;
            if (wstrb_ff[0]) begin
                if (awaddr_ff[11:5] == 7'h00 && awaddr_ff[4:2] < 3'h6
                    && awaddr_ff[1:0] == 2'h0) begin
                    func_ff[awaddr_ff[4:2]] <= wdata_ff[5:0];
                end
                if (awaddr_ff == `OFS_POLARITY) begin
                    polarity_ff <= wdata_ff[5:0];
                end
                if (awaddr_ff == `OFS_CONFIG) begin
                    config_ff <= wdata_ff[5:0];
                end
            end
        end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end
end

// read side: one word, registered answer
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        s_rvalid_o <= 1'b0;
        s_rdata_o <= 32'h00000000;
        s_rresp_o <= 2'h0;
    end else if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o <= 2'h0;
        s_rdata_o <= 32'h00000000;
        if (s_araddr_i[11:5] == 7'h00 && s_araddr_i[4:2] < 3'h6) begin
            s_rdata_o <= {26'h0, func_ff[s_araddr_i[4:2]]};
        end else begin
            case (s_araddr_i)
                `OFS_POLARITY: s_rdata_o <= {26'h0, polarity_ff};
                `OFS_CONFIG: s_rdata_o <= {26'h0, config_ff};
                `OFS_STATUS: s_rdata_o <= {19'h0, three_wire_ff, act,
                    running_i, seq_suspended_i, motor_group_o,
                    torque_mode_o, pid_gain_second_o};
                `OFS_COUNTER: s_rdata_o <= counter_ff;
                `OFS_LENGTH: s_rdata_o <= length_ff;
                `OFS_CMD: s_rdata_o <= 32'h00000000;
                `OFS_FUNC_STAT: s_rdata_o <= fn_act[63:32];
                default: s_rresp_o <= 2'h2;
            endcase
        end
    end else if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
    end
end

// ==========================================================
// terminal sampling, counters and wire mode
// counting on rising edges only so a held level counts once
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        term_ff <= 6'h00;
        last_act_ff <= 6'h00;
        counter_ff <= 32'h00000000;
        length_ff <= 32'h00000000;
        three_wire_ff <= 1'b0;
    end else begin
        term_ff <= term_i;
        last_act_ff <= act;
        // clear wins: a held reset keeps the count at zero
        if (fn_act[`FN_CNT_RST] || (cmd_wr && wdata_ff[0])) begin
            counter_ff <= 32'h00000000;
        end else if (fn_rise[`FN_CNT_IN]) begin
            counter_ff <= counter_ff + 32'h00000001;
        end
        if (fn_act[`FN_LEN_RST] || (cmd_wr && wdata_ff[1])) begin
            length_ff <= 32'h00000000;
        end else if (fn_rise[`FN_LEN_IN]) begin
            length_ff <= length_ff + 32'h00000001;
        end
        if (cmd_wr && wdata_ff[2]) begin
            three_wire_ff <= config_ff[`CFG_THREE_WIRE_BIT];
        end else if (fn_rise[`FN_WIRE_SW] && !running_i) begin
            three_wire_ff <= !three_wire_ff;
        end
    end
end

// ==========================================================
// command outputs, registered
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        stop_key_o <= 1'b0;
        decel_stop_o <= 1'b0;
        decel_sel_o <= 2'h0;
        estop_o <= 1'b0;
        pid_hold_o <= 1'b0;
        pid_int_freeze_o <= 1'b0;
        pid_dir_invert_o <= 1'b0;
        pid_gain_second_o <= 1'b0;
        seq_pause_o <= 1'b0;
        seq_restart_o <= 1'b0;
        swing_pause_o <= 1'b0;
        swing_center_o <= 1'b0;
        torque_mode_o <= 1'b0;
        freq_hold_o <= 1'b0;
        rev_block_o <= 1'b0;
        setpoint_hold_o <= 1'b0;
        motor_group_o <= 2'h0;
        user_fault1_o <= 1'b0;
        user_fault2_o <= 1'b0;
        runtime_clr_o <= 1'b0;
        three_wire_o <= 1'b0;
    end else begin
        stop_key_o <= fn_act[`FN_STOP_EXT1] &&
            config_ff[1:0] == `SRC_KEYPAD;
        decel_stop_o <= fn_act[`FN_STOP_EXT2];
        decel_sel_o <= fn_act[`FN_STOP_EXT2] ? `DECEL_SEL_FOURTH : 2'h0;
        estop_o <= fn_act[`FN_ESTOP];
        pid_hold_o <= fn_act[`FN_PID_PAUSE];
        pid_int_freeze_o <= fn_act[`FN_PID_INT_PAUSE];
        pid_dir_invert_o <= fn_act[`FN_PID_REVERSE];
        pid_gain_second_o <= fn_act[`FN_PID_GAIN_SW] &&
            config_ff[3:2] == `GAIN_SW_TERMINAL;
        seq_pause_o <= fn_act[`FN_SEQ_PAUSE];
        seq_restart_o <= fn_act[`FN_SEQ_RESET] && seq_suspended_i;
        swing_pause_o <= fn_act[`FN_SWING_PAUSE];
        swing_center_o <= fn_act[`FN_SWING_PAUSE] ||
            fn_act[`FN_SWING_RESET];
        // prohibit overrides the mode swap
        torque_mode_o <= !fn_act[`FN_TORQUE_PROHIBIT] &&
            (config_ff[`CFG_TORQUE_BIT] ^ fn_act[`FN_MODE_SW]);
        // stop requests pass regardless, the hold only freezes ramps
        freq_hold_o <= fn_act[`FN_RAMP_PROHIBIT] ||
            fn_act[`FN_PID_PAUSE];
        rev_block_o <= fn_act[`FN_REV_PROHIBIT];
        setpoint_hold_o <= fn_act[`FN_FREQ_PROHIBIT];
        motor_group_o <= motor_bits;
        user_fault1_o <= fn_act[`FN_USER_FAULT1];
        user_fault2_o <= fn_act[`FN_USER_FAULT2];
        runtime_clr_o <= fn_act[`FN_RUNTIME_CLR];
        three_wire_o <= three_wire_ff;
    end
end

endmodule // di_func_decoder
`default_nettype wire

// ===== sim/contact_model.sv
// model of the switch contacts on the input terminals
`timescale 1ns/10ps
`default_nettype none
module contact_model (
    input wire logic core_clk_i,
    output var logic [5:0] term_o
);
    // contacts start open; moves land just after an edge so the
    // decoder never samples a level mid-change
    initial term_o = 6'h00;
    task automatic press(input int idx, input logic lvl);
        @(posedge core_clk_i);
        term_o[idx] <= lvl;
    endtask
endmodule // contact_model
`default_nettype wire

// ===== sim/di_func_asserts.sv
// concurrent checks on the input decoder ports
`timescale 1ns/10ps
`default_nettype none
module di_func_asserts (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic s_awvalid_i,
    input wire logic s_awready_o,
    input wire logic s_wvalid_i,
    input wire logic s_wready_o,
    input wire logic [1:0] s_bresp_o,
    input wire logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [11:0] s_araddr_i,
    input wire logic s_arvalid_i,
    input wire logic s_arready_o,
    input wire logic [31:0] s_rdata_o,
    input wire logic [1:0] s_rresp_o,
    input wire logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire logic running_i,
    input wire logic decel_stop_o,
    input wire logic [1:0] decel_sel_o,
    input wire logic three_wire_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================================
    // bus steps
    sequence wr_both;
        s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
    endsequence
    sequence rd_take;
        s_arvalid_i && s_arready_o;
    endsequence
    // both halves are latched first, the answer follows a cycle later
    wr_answer_a: assert property (wr_both |=> ##1 s_bvalid_o)
        else $error("write response late");
    rd_answer_a: assert property (rd_take |=> s_rvalid_o)
        else $error("read response late");
    b_hold_a: assert property (s_bvalid_o && !s_bready_i |=>
        s_bvalid_o && $stable(s_bresp_o)) else $error("bresp dropped");
    r_hold_a: assert property (s_rvalid_o && !s_rready_i |=>
        s_rvalid_o && $stable(s_rdata_o)) else $error("rdata dropped");
    ar_block_a: assert property (s_rvalid_o |-> !s_arready_o)
        else $error("read taken while busy");
    // addresses past the map answer slave error and zero data
    unmapped_rd_a: assert property (s_arvalid_i && s_arready_o
        && s_araddr_i >= 12'h03C
        |=> s_rresp_o == 2'h2 && s_rdata_o == 32'h0)
        else $error("unmapped read accepted");
    // ==========================================================
    // command outputs
    decel_ramp_a: assert property (decel_stop_o |-> decel_sel_o == 2'h3)
        else $error("stop 2 without fourth ramp");
    // a toggle request while running must leave the wire mode alone
    wire_run_a: assert property ((running_i && !s_wvalid_i)[*3]
        |=> $stable(three_wire_o)) else $error("wire mode moved");
endmodule // di_func_asserts
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the input function decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk_i, rst_i, running_i, seq_suspended_i;
    logic [11:0] s_awaddr_i, s_araddr_i;
    logic [31:0] s_wdata_i, s_rdata_o, rv;
    logic [3:0] s_wstrb_i;
    logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o;
    logic s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
    logic [1:0] s_bresp_o, s_rresp_o, decel_sel_o, motor_group_o, rr;
    logic stop_key_o, decel_stop_o, estop_o, pid_hold_o, pid_int_freeze_o;
    logic pid_dir_invert_o, pid_gain_second_o, seq_pause_o, seq_restart_o;
    logic swing_pause_o, swing_center_o, torque_mode_o, freq_hold_o;
    logic rev_block_o, setpoint_hold_o, user_fault1_o, user_fault2_o;
    logic runtime_clr_o, three_wire_o;
    wire logic [5:0] term_i;
    int error_cnt = 0;
    int check_count = 0;
    // one bit per function, in function-code order
    wire logic [17:0] cmds = {runtime_clr_o, user_fault2_o, user_fault1_o,
        setpoint_hold_o, rev_block_o, freq_hold_o, torque_mode_o,
        swing_center_o, swing_pause_o, seq_restart_o, seq_pause_o,
        pid_gain_second_o, pid_dir_invert_o, pid_int_freeze_o,
        pid_hold_o, estop_o, decel_stop_o, stop_key_o};
    di_func_decoder u_dut (.*);
    contact_model u_term (.core_clk_i, .term_o(term_i));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // ==========================================================
    // bus master: every handshake is judged at the rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge core_clk_i);
        s_awaddr_i <= a;
        s_wdata_i <= d;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        while (!b) begin
            @(posedge core_clk_i);
            if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'b0;
            if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'b0;
            if (s_bvalid_o) begin
                b = 1'b1;
                rr = s_bresp_o;
            end
        end
        s_bready_i <= 1'b0;
        chk("bresp", 0, rr);
    endtask
    task automatic rd(input logic [11:0] a);
        logic r;
        r = 1'b0;
        @(posedge core_clk_i);
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        while (!r) begin
            @(posedge core_clk_i);
            if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'b0;
            if (s_rvalid_o) begin
                r = 1'b1;
                rv = s_rdata_o;
                rr = s_rresp_o;
            end
        end
        s_rready_i <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_levels;
        wr(12'h024, 32'h4);
        seq_suspended_i <= 1'b1;
        for (int i = 0; i < 18; i++) begin
            int e;
            // PID pause also holds frequency, swing pause also centres
            e = (1 << i) | (i == 3 ? 'h1000 : 0) | (i == 9 ? 'h400 : 0);
            wr(12'h000, i < 12 ? 'h1C + i : i < 15 ? 'h1D + i : 'h23 + i);
            u_term.press(0, 1'b1);
            settle;
            chk("on", e, cmds);
            u_term.press(0, 1'b0);
            settle;
            chk("off", 0, cmds);
        end
        seq_suspended_i <= 1'b0;
        rd(12'hFFC);
        chk("unmapped", 32'h2, {rv[29:0], rr});
    endtask
    task automatic t_polarity;
        wr(12'h014, 32'h1E);
        wr(12'h020, 32'h20);
        settle;
        chk("estop low", 1, estop_o);
        u_term.press(5, 1'b1);
        settle;
        chk("estop high", 0, estop_o);
        wr(12'h020, 32'h0);
        wr(12'h014, 32'h0);
        u_term.press(5, 1'b0);
    endtask
    task automatic t_source;
        wr(12'h024, 32'h1);
        wr(12'h000, 32'h1C);
        wr(12'h004, 32'h27);
        wr(12'h008, 32'h28);
        for (int i = 0; i < 3; i++) u_term.press(i, 1'b1);
        settle;
        chk("stop key", 0, stop_key_o);
        chk("prohibit", 0, torque_mode_o);
        u_term.press(2, 1'b0);
        settle;
        chk("torque", 1, torque_mode_o);
        u_term.press(1, 1'b0);
        u_term.press(0, 1'b0);
        wr(12'h024, 32'h0);
    endtask
    task automatic t_motor;
        wr(12'h000, 32'h30);
        wr(12'h004, 32'h30);
        for (int m = 0; m < 4; m++) begin
            u_term.press(0, m[0]);
            u_term.press(1, m[1]);
            settle;
            chk("motor", m, motor_group_o);
        end
        u_term.press(0, 1'b0);
        u_term.press(1, 1'b0);
    endtask
    task automatic t_count(input logic [31:0] f, input logic [11:0] ofs);
        wr(12'h000, f);
        wr(12'h004, f + 32'h1);
        repeat (3) begin
            u_term.press(0, 1'b1);
            settle;
            u_term.press(0, 1'b0);
            settle;
        end
        rd(ofs);
        chk("count", 3, rv);
        u_term.press(1, 1'b1);
        settle;
        rd(ofs);
        chk("cleared", 0, rv);
        u_term.press(1, 1'b0);
    endtask
    task automatic t_wire;
        wr(12'h000, 32'h35);
        running_i <= 1'b1;
        u_term.press(0, 1'b1);
        settle;
        u_term.press(0, 1'b0);
        chk("wire run", 0, three_wire_o);
        running_i <= 1'b0;
        for (int k = 1; k < 3; k++) begin
            u_term.press(0, 1'b1);
            settle;
            chk("wire", k & 1, three_wire_o);
            u_term.press(0, 1'b0);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence; the watchdog is far beyond the few hundred
    // cycles the scenarios need
    initial begin
        {rst_i, s_wstrb_i} = 5'h1F;
        {running_i, seq_suspended_i, s_awaddr_i, s_araddr_i} = 26'h0;
        {s_wdata_i, s_awvalid_i, s_wvalid_i, s_bready_i} = 35'h0;
        {s_arvalid_i, s_rready_i} = 2'h0;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_levels;
        t_polarity;
        t_source;
        t_motor;
        t_count(32'h2C, 12'h02C);
        t_count(32'h2E, 12'h030);
        t_wire;
        report_and_stop;
    end
    initial begin
        #2000000;
        error_cnt++;
        report_and_stop;
    end
endmodule // testbench
bind di_func_decoder di_func_asserts u_chk (.*);
`default_nettype wire
